// ### shared/alarm_defines.svh
`ifndef ALARM_DEFINES_SVH
`define ALARM_DEFINES_SVH

// Register offsets on the 8-bit register port.
`define OFS_EVENT_LATCH 8'h00
`define OFS_EVENT_CLEAR 8'h01
`define OFS_EVENT_ENABLE 8'h02
`define OFS_EDGE_SELECT 8'h03
`define OFS_LIVE_ALARM 8'h04

// Bit positions of the latched event register.
`define BIT_AMPLITUDE 7
`define BIT_TX_JITTER 6
`define BIT_RX_JITTER 5
`define BIT_OVERCURRENT 4
`define BIT_TX_CLOCK_LOSS 3
`define BIT_TX_LOSS 2
`define BIT_SYSTEM_LOSS 1
`define BIT_LINE_LOSS 0

// Reset values and the writable bits of the edge select register.
`define EVENT_LATCH_RESET 8'h00
`define EVENT_ENABLE_RESET 8'hFF
`define EDGE_SELECT_RESET 8'h00
`define EDGE_SELECT_MASK 8'h16

// Transmit clock supervision: no clock edge for this long means missing.
`define CORE_CLK_PERIOD_NS 8
`define TCLK_MISS_NS 2000
`define TCLK_MISS_CYCLES ((`TCLK_MISS_NS) / (`CORE_CLK_PERIOD_NS))

`endif

// ### shared/alarm_pkg.sv
package alarm_pkg;

  // One register port request, sampled on the rising clock edge.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // One-cycle fault pulses from logic on the core clock.
  typedef struct packed {
    logic amplitude_overflow;
    logic tx_jitter_fifo;
    logic rx_jitter_fifo;
  } fault_pulse_t;

  // Live alarm levels arriving from outside the clock domain.
  typedef struct packed {
    logic overcurrent;
    logic tx_loss;
    logic system_loss;
    logic line_loss;
  } live_pins_t;

endpackage

// ### hdl/edge_event_detect.sv
module edge_event_detect #(
  parameter int WIDTH = 5
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] live,
  input wire logic [WIDTH-1:0] any_edge,
  output logic [WIDTH-1:0] set_pulse
);

  logic [WIDTH-1:0] prev_q;

  // Remembers each live bit so that transitions can be seen.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prev_q <= '0;
    end else begin
      prev_q <= live;
    end
  end

  // Rising edges always count; falling edges count when any_edge is set.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign set_pulse[i] = (live[i] & ~prev_q[i]) |
                            (any_edge[i] & ~live[i] & prev_q[i]);
    end
  endgenerate

endmodule

// ### hdl/tx_clock_monitor.sv
module tx_clock_monitor (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic channel_tx_clock,
  output logic clock_edge,
  output logic tx_clock_loss_live
);

  `include "alarm_defines.svh"

  localparam logic [7:0] MISS_LIMIT = 8'(`TCLK_MISS_CYCLES);

  logic meta_q;
  logic sync_q;
  logic last_q;
  logic [7:0] idle_q;
  logic [7:0] idle_d;
  logic loss_q;

  // Two-stage synchroniser, then one more stage for edge detection.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= channel_tx_clock;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  // Any transition of the sampled clock counts as activity.
  assign clock_edge = sync_q ^ last_q;
  assign idle_d = clock_edge ? 8'h00 :
                  (idle_q == MISS_LIMIT) ? idle_q : idle_q + 8'h01;

  // Counts idle cycles; the loss flag follows the saturated count.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      idle_q <= 8'h00;
      loss_q <= 1'b0;
    end else begin
      idle_q <= idle_d;
      loss_q <= (idle_d == MISS_LIMIT);
    end
  end

  assign tx_clock_loss_live = loss_q;

endmodule

// ### hdl/line_alarm_interrupt_status.sv
`include "alarm_defines.svh"

// Behaviour
// - Bit 7 latches transmit amplitude overflow and raises interrupt.
// - Bit 6 latches on transmit jitter FIFO overflow or underflow.
// - Bit 5 latches on receive jitter FIFO overflow or underflow.
// - Latched bits reset to zero; writing one clears, zero leaves it.
// - Bit 4 latches overcurrent; rising edge only unless its edge bit.
// - Bit 2 latches transmit loss; edge select bit 2 picks edges.
// - Bit 1 latches system loss; shared edge select bit 1 picks edges.
// - Bit 0 latches line loss with the same shared edge select bit.
// - Live clock loss reads one while the transmit clock is missing.
module line_alarm_interrupt_status (
  input wire logic core_clk,
  input wire logic resetn,
  input wire alarm_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire alarm_pkg::fault_pulse_t fault_pulse,
  input wire alarm_pkg::live_pins_t live_pins,
  input wire logic channel_tx_clock,
  output logic irq
);

  import alarm_pkg::*;

  // Decodes one register offset from the request.
  function automatic logic addr_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
    addr_hit = (addr == ofs);
  endfunction

  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  logic clock_edge;
  logic tx_clock_loss_live;
  logic [4:0] live_alarm;
  logic [4:0] any_edge;
  logic [4:0] edge_set;
  logic [7:0] event_set;
  logic [7:0] event_clear;
  logic [7:0] alarm_event_latch_0_q;
  logic [7:0] alarm_event_latch_0_d;
  logic [7:0] event_enable_q;
  logic [7:0] edge_select_register_q;
  logic [7:0] rdata_d;
  logic [7:0] reg_rdata_q;
  logic wr_latch;
  logic wr_clear;
  logic wr_enable;
  logic wr_edge;
  logic rd_latch;
  logic rd_enable;
  logic rd_edge;
  logic rd_live;
  logic overcurrent_live;
  logic tx_loss_live;
  logic system_loss_live;
  logic line_loss_live;
  logic overcurrent_edge_select;
  logic tx_loss_edge_select;
  logic loss_edge_select;

  // Live levels from outside pass two flip-flops before any logic.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pin_meta_q <= 4'h0;
      pin_sync_q <= 4'h0;
    end else begin
      pin_meta_q <= live_pins;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign overcurrent_live = pin_sync_q[3];
  assign tx_loss_live = pin_sync_q[2];
  assign system_loss_live = pin_sync_q[1];
  assign line_loss_live = pin_sync_q[0];

  // Watches the transmit clock pin and reports when it stops.
  tx_clock_monitor u_clock_monitor (
    .core_clk(core_clk),
    .resetn(resetn),
    .channel_tx_clock(channel_tx_clock),
    .clock_edge(clock_edge),
    .tx_clock_loss_live(tx_clock_loss_live)
  );

  // Live alarm word, laid out like the lower five latch bits.
  assign live_alarm = {overcurrent_live, tx_clock_loss_live, tx_loss_live,
                       system_loss_live, line_loss_live};

  // Edge select fields; bit 1 is shared by the two loss-of-signal sources.
  assign overcurrent_edge_select = edge_select_register_q[`BIT_OVERCURRENT];
  assign tx_loss_edge_select = edge_select_register_q[`BIT_TX_LOSS];
  assign loss_edge_select = edge_select_register_q[`BIT_SYSTEM_LOSS];

  // Per-source edge policy; clock loss always reacts to both edges.
  assign any_edge[4] = overcurrent_edge_select;
  assign any_edge[3] = 1'b1;
  assign any_edge[2] = tx_loss_edge_select;
  assign any_edge[1] = loss_edge_select;
  assign any_edge[0] = loss_edge_select;

  // Turns live transitions into one-cycle set pulses.
  edge_event_detect #(
    .WIDTH(5)
  ) u_edge_detect (
    .core_clk(core_clk),
    .resetn(resetn),
    .live(live_alarm),
    .any_edge(any_edge),
    .set_pulse(edge_set)
  );

  // Register port decode.
  assign wr_latch = reg_req.wr & addr_hit(reg_req.addr, `OFS_EVENT_LATCH);
  assign wr_clear = reg_req.wr & addr_hit(reg_req.addr, `OFS_EVENT_CLEAR);
  assign wr_enable = reg_req.wr & addr_hit(reg_req.addr, `OFS_EVENT_ENABLE);
  assign wr_edge = reg_req.wr & addr_hit(reg_req.addr, `OFS_EDGE_SELECT);
  assign rd_latch = reg_req.rd & addr_hit(reg_req.addr, `OFS_EVENT_LATCH);
  assign rd_enable = reg_req.rd & addr_hit(reg_req.addr, `OFS_EVENT_ENABLE);
  assign rd_edge = reg_req.rd & addr_hit(reg_req.addr, `OFS_EDGE_SELECT);
  assign rd_live = reg_req.rd & addr_hit(reg_req.addr, `OFS_LIVE_ALARM);

  // Event sources and the write-one-to-clear mask.
  assign event_set = {fault_pulse.amplitude_overflow,
                      fault_pulse.tx_jitter_fifo,
                      fault_pulse.rx_jitter_fifo,
                      edge_set};
  assign event_clear = (wr_latch | wr_clear) ? reg_req.wdata : 8'h00;

  // A set in the same cycle as its clear wins, so no event is lost.
  assign alarm_event_latch_0_d =
    (alarm_event_latch_0_q & ~event_clear) | event_set;

  // Sticky event latch.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      alarm_event_latch_0_q <= `EVENT_LATCH_RESET;
    end else begin
      alarm_event_latch_0_q <= alarm_event_latch_0_d;
    end
  end

  // Enable and edge select registers.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      event_enable_q <= `EVENT_ENABLE_RESET;
      edge_select_register_q <= `EDGE_SELECT_RESET;
    end else begin
      if (wr_enable) begin
        event_enable_q <= reg_req.wdata;
      end
      if (wr_edge) begin
        edge_select_register_q <= reg_req.wdata & `EDGE_SELECT_MASK;
      end
    end
  end

  // Read multiplexer; the clear register and unmapped offsets read zero.
  assign rdata_d = rd_latch ? alarm_event_latch_0_q :
                   rd_enable ? event_enable_q :
                   rd_edge ? edge_select_register_q :
                   rd_live ? {3'h0, live_alarm} : 8'h00;

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      reg_rdata_q <= 8'h00;
    end else begin
      reg_rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = reg_rdata_q;

  // Level interrupt while any enabled latched event is pending.
  assign irq = |(alarm_event_latch_0_q & event_enable_q);

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  // Amplitude overflow is latched and shows on the interrupt if enabled.
  chk_amp_to_irq: assert property (
    fault_pulse.amplitude_overflow && event_enable_q[`BIT_AMPLITUDE]
    && !wr_enable
    |=> alarm_event_latch_0_q[`BIT_AMPLITUDE] && irq)
    else $error("amplitude overflow not latched onto interrupt");

  // Transmit jitter FIFO fault latches even against a clear.
  chk_tx_jitter_latch: assert property (
    fault_pulse.tx_jitter_fifo
    |=> alarm_event_latch_0_q[`BIT_TX_JITTER])
    else $error("transmit jitter event not latched");

  // Receive jitter FIFO fault latches.
  chk_rx_jitter_latch: assert property (
    fault_pulse.rx_jitter_fifo
    |=> alarm_event_latch_0_q[`BIT_RX_JITTER])
    else $error("receive jitter event not latched");

  // A full clear with no new events empties the latch; zeros keep bits.
  chk_clear_ones: assert property (
    wr_clear && reg_req.wdata == 8'hFF && event_set == 8'h00
    |=> alarm_event_latch_0_q == 8'h00)
    else $error("write of ones did not clear the latch");

  chk_clear_zeros: assert property (
    (wr_latch || wr_clear) && reg_req.wdata == 8'h00 && event_set == 8'h00
    |=> alarm_event_latch_0_q == $past(alarm_event_latch_0_q))
    else $error("write of zeros changed the latch");

  // Overcurrent: a fall is ignored in rising-only mode.
  chk_oc_fall_ignored: assert property (
    $fell(overcurrent_live) && !overcurrent_edge_select
    && !alarm_event_latch_0_q[`BIT_OVERCURRENT]
    |=> !alarm_event_latch_0_q[`BIT_OVERCURRENT])
    else $error("overcurrent fall latched in rising-only mode");

  chk_oc_rise_latch: assert property (
    $rose(overcurrent_live)
    |=> alarm_event_latch_0_q[`BIT_OVERCURRENT])
    else $error("overcurrent rise not latched");

  // Overcurrent: a fall latches once any-edge mode is selected.
  chk_oc_any_fall: assert property (
    $fell(overcurrent_live) && overcurrent_edge_select
    |=> alarm_event_latch_0_q[`BIT_OVERCURRENT])
    else $error("overcurrent fall not latched in any-edge mode");

  // Transmit loss falls latch in any-edge mode.
  chk_tx_loss_fall: assert property (
    $fell(tx_loss_live) && tx_loss_edge_select
    |=> alarm_event_latch_0_q[`BIT_TX_LOSS])
    else $error("transmit loss fall not latched in any-edge mode");

  // Transmit loss rises latch in either mode.
  chk_tx_loss_rise: assert property (
    $rose(tx_loss_live)
    |=> alarm_event_latch_0_q[`BIT_TX_LOSS])
    else $error("transmit loss rise not latched");

  // System and line loss follow the shared select bit.
  chk_sys_loss_edge: assert property (
    $changed(system_loss_live) && (loss_edge_select || system_loss_live)
    |=> alarm_event_latch_0_q[`BIT_SYSTEM_LOSS])
    else $error("system loss transition not latched");

  chk_line_loss_edge: assert property (
    $fell(line_loss_live) && !loss_edge_select
    && !alarm_event_latch_0_q[`BIT_LINE_LOSS]
    |=> !alarm_event_latch_0_q[`BIT_LINE_LOSS])
    else $error("line loss fall latched in rising-only mode");

  // Clock loss clears in the cycle after clock activity.
  chk_clock_present: assert property (
    clock_edge |=> !tx_clock_loss_live)
    else $error("clock loss reported while clock toggles");

  // Counts quiet cycles of the sampled transmit clock for the loss checks.
  localparam logic [8:0] QUIET_LIMIT = 9'(`TCLK_MISS_CYCLES);
  logic [8:0] quiet_q;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      quiet_q <= 9'h000;
    end else if (clock_edge) begin
      quiet_q <= 9'h000;
    end else if (quiet_q != 9'h1FF) begin
      quiet_q <= quiet_q + 9'h001;
    end
  end

  // A clock that stays quiet past the limit must read as missing.
  chk_clock_missing: assert property (
    quiet_q > QUIET_LIMIT |-> tx_clock_loss_live)
    else $error("clock loss not reported while clock is missing");

  // Loss is only reported after the full quiet span.
  chk_loss_needs_quiet: assert property (
    tx_clock_loss_live |-> quiet_q >= QUIET_LIMIT)
    else $error("clock loss reported too early");

  // Any clock loss change latches bit 3.
  chk_clock_loss_latch: assert property (
    $changed(tx_clock_loss_live)
    |=> alarm_event_latch_0_q[`BIT_TX_CLOCK_LOSS])
    else $error("clock loss change not latched");

  // Read data appear one cycle after the strobe and vanish after.
  chk_read_timing: assert property (
    rd_latch && !reg_req.wr ##1 !reg_req.rd
    |-> reg_rdata == $past(alarm_event_latch_0_q) ##1 reg_rdata == 8'h00)
    else $error("read data timing wrong");

  cov_amp_irq: cover property (
    fault_pulse.amplitude_overflow ##1 irq ##[1:8] wr_clear ##1 !irq);
  cov_any_edge_loss: cover property (
    loss_edge_select && $fell(line_loss_live));
  cov_clock_lost: cover property ($rose(tx_clock_loss_live));
  cov_set_and_clear: cover property (
    wr_clear && (event_set & reg_req.wdata) != 8'h00);
  cov_oc_any_fall: cover property (
    overcurrent_edge_select && $fell(overcurrent_live));

endmodule

// ### testbench/line_alarm_interrupt_status_bench.sv
module line_alarm_interrupt_status_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import alarm_pkg::*;

  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  reg_req_t req = '0;
  logic [7:0] rdata;
  fault_pulse_t faults = '0;
  live_pins_t pins = '0;
  logic tx_clk = 1'b0;
  logic tx_run = 1'b1;
  logic [1:0] tx_div = 2'h0;
  logic irq;
  int num_errors = 0;
  int n_tests = 0;

  line_alarm_interrupt_status i_dut (
    .core_clk(core_clk),
    .resetn(resetn),
    .reg_req(req),
    .reg_rdata(rdata),
    .fault_pulse(faults),
    .live_pins(pins),
    .channel_tx_clock(tx_clk),
    .irq(irq)
  );

  // Core clock at 125 MHz.
  always #4 core_clk = ~core_clk;

  // Transmit clock near 15.6 MHz; it stands still while tx_run is low.
  always @(posedge core_clk) begin
    tx_div <= tx_div + 2'h1;
    if (tx_run && tx_div == 2'h3) begin
      tx_clk <= ~tx_clk;
    end
  end

  // Compares a register value and counts the outcome.
  task automatic check_reg(input logic [7:0] got, input logic [7:0] exp,
                           input string what);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what,
               got, exp);
    end
  endtask

  // Compares the interrupt output and counts the outcome.
  task automatic check_irq(input logic exp);
    n_tests++;
    if (irq !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: irq got %b expected %b", $time, irq,
               exp);
    end
  endtask

  // One write cycle on the register port.
  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    req.addr <= addr;
    req.wdata <= data;
    req.wr <= 1'b1;
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask

  // One read cycle; the data stand only in the cycle after the strobe.
  task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp,
                        input string what);
    @(posedge core_clk);
    req.addr <= addr;
    req.rd <= 1'b1;
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    check_reg(rdata, exp, what);
  endtask

  // Lets the synchroniser and edge detector settle after a pin change.
  task automatic settle();
    repeat (5) @(posedge core_clk);
  endtask

  // Reset values, the edge select mask and unmapped places.
  task automatic test_reset_values();
    reg_rd(8'h00, 8'h00, "latch reset");
    reg_rd(8'h02, 8'hFF, "enable reset");
    reg_rd(8'h03, 8'h00, "edge reset");
    reg_rd(8'h04, 8'h00, "live reset");
    check_irq(1'b0);
    reg_wr(8'h03, 8'hFF);
    reg_rd(8'h03, 8'h16, "edge mask");
    reg_wr(8'h03, 8'h00);
    reg_wr(8'h04, 8'hFF);
    reg_rd(8'h04, 8'h00, "live write ignored");
    reg_rd(8'h05, 8'h00, "unmapped read");
  endtask

  // Each fault pulse latches its bit; zero writes keep it, one clears it.
  task automatic test_fault_pulses();
    logic [7:0] bitv;
    for (int i = 0; i < 3; i++) begin
      bitv = 8'h80 >> i;
      @(posedge core_clk);
      faults <= fault_pulse_t'(3'h4 >> i);
      @(posedge core_clk);
      faults <= '0;
      reg_rd(8'h00, bitv, "fault latch");
      check_irq(1'b1);
      reg_wr(8'h01, 8'h00);
      reg_rd(8'h00, bitv, "zero write keeps");
      reg_wr(8'h01, bitv);
      reg_rd(8'h00, 8'h00, "one write clears");
      check_irq(1'b0);
    end
  endtask

  // Live pins under rising-only and any-edge selection.
  task automatic test_edge_select();
    logic [7:0] lb [4] = '{8'h10, 8'h04, 8'h02, 8'h01};
    logic [7:0] sb [4] = '{8'h10, 8'h04, 8'h02, 8'h02};
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'h03, 8'h00);
      @(posedge core_clk);
      pins <= live_pins_t'(4'h8 >> i);
      settle();
      reg_rd(8'h00, lb[i], "rise latch");
      check_irq(1'b1);
      reg_wr(8'h01, 8'hFF);
      pins <= '0;
      settle();
      reg_rd(8'h00, 8'h00, "fall ignored");
      reg_wr(8'h03, sb[i]);
      pins <= live_pins_t'(4'h8 >> i);
      settle();
      reg_rd(8'h00, lb[i], "any rise");
      reg_rd(8'h04, 8'h10 >> (i + (i > 0)), "live level");
      reg_wr(8'h01, 8'hFF);
      pins <= '0;
      settle();
      reg_rd(8'h00, lb[i], "any fall");
      reg_wr(8'h01, 8'hFF);
    end
    reg_wr(8'h03, 8'h00);
  endtask

  // Transmit clock stops, then returns; both changes latch bit 3.
  task automatic test_clock_loss();
    tx_run <= 1'b0;
    repeat (270) @(posedge core_clk);
    reg_rd(8'h04, 8'h08, "clock missing");
    reg_rd(8'h00, 8'h08, "loss latch");
    check_irq(1'b1);
    reg_wr(8'h01, 8'h08);
    reg_rd(8'h00, 8'h00, "loss cleared");
    tx_run <= 1'b1;
    repeat (20) @(posedge core_clk);
    reg_rd(8'h04, 8'h00, "clock present");
    reg_rd(8'h00, 8'h08, "return latch");
    reg_wr(8'h00, 8'h08);
    reg_rd(8'h00, 8'h00, "latch offset clear");
  endtask

  // The enable register masks the interrupt but not the latch.
  task automatic test_enable_mask();
    reg_wr(8'h02, 8'h00);
    reg_rd(8'h02, 8'h00, "enable write");
    @(posedge core_clk);
    faults <= 3'h2;
    @(posedge core_clk);
    faults <= '0;
    reg_rd(8'h00, 8'h40, "masked latch");
    check_irq(1'b0);
    reg_wr(8'h02, 8'h40);
    #1;
    check_irq(1'b1);
    reg_wr(8'h01, 8'h40);
    #1;
    check_irq(1'b0);
    reg_wr(8'h02, 8'hFF);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run of about 560 cycles.
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end

  // Holds reset for 20 cycles, then runs every scenario in turn.
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    test_reset_values();
    test_fault_pulses();
    test_edge_select();
    test_clock_loss();
    test_enable_mask();
    test_done();
  end
endmodule
